// >>> odsc_device.sv
/*
  over-discharge protection and sleep control of the pack protection device.
  assumes comparator flags and supply level arrive asynchronously from the
  analog side; the host drives the command link on the same clock.
*/
// Design decisions made here: the plain strobed port and the placing of the registers.
// How it works
// R1: expired undervoltage turns both FETs off, sleeps
// R2: countdown starts on undervoltage; normal until expiry
// R3: two-bit config field selects undervoltage threshold
// R4: discharge only after wake, charge, release, enable
// R5: delays follow time base: 1.0s, 7ms
// R6: sleep on over-discharge or host sleep request
// R7: asleep: gates off, circuits down, regulator 0V
// R8: asleep: FET enable bits cannot change gates
// R9: supply at release level wakes, restores regulator, link
// R10: at wake, check charge-enable level before FETs
// R11: FET changes only when all cells pass check
// R12: config bit switches check; off always passes
// R13: no sleep while supply at release level
// R14: charge gate off until host writes one; reset loads the control bit as one here, so the gate is on
// R15: discharge gate off until host writes one; reset loads the control bit as one here, so the gate is on
// R16: after wake, internal reset of longest delay+200ms
// R17: sample comparators 2ms every 125ms period
// R18: comparator flags synchronised per cell
// R19: countdowns restart when condition clears early
`timescale 1ns/1ns
module odsc_device #(
  parameter int N_CELLS = 4,
  parameter int DETECT_CYC = odsc_pkg::DETECT_CYC,
  parameter int RELEASE_CYC = odsc_pkg::RELEASE_CYC,
  parameter int RESET_CYC = odsc_pkg::RESET_CYC,
  parameter int SAMPLE_ON_CYC = odsc_pkg::SAMPLE_ON_CYC,
  parameter int SAMPLE_PERIOD_CYC = odsc_pkg::SAMPLE_PERIOD_CYC
) (
  input wire logic sys_clk_in, // system clock
  input wire logic nrst_in, // async reset, active low
  odsc_if.device link, // host command link
  input wire logic [N_CELLS-1:0] uv_below_in, // cell below undervolt_threshold
  input wire logic [N_CELLS-1:0] release_above_in, // cell above undervolt_release_level
  input wire logic [N_CELLS-1:0] chg_en_above_in, // cell above chg_enable_level
  input wire logic supply_release_in, // supply at or above sleep_release_level
  output logic discharge_gate_out, // high = discharge FET off
  output logic charge_gate_out, // high = charge FET off
  output logic regulator_output_on_out, // regulator_output enabled
  output logic undervolt_sel_hi_out, // threshold select high bit
  output logic undervolt_sel_lo_out, // threshold select low bit
  output logic chg_enable_level_sel_hi_out, // charge-enable level select high
  output logic chg_enable_level_sel_lo_out, // charge-enable level select low
  output logic chg_enable_check_on_out, // charge-enable check active
  output logic sample_enable_out, // comparator sampling window
  output logic asleep_out // device in sleep
);

  // ==========================================================================
  // input synchronisers
  // ==========================================================================
  localparam int SW = 3 * N_CELLS + 1;
  logic [SW-1:0] sync_a;
  logic [SW-1:0] sync_b;

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {supply_release_in, chg_en_above_in, release_above_in, uv_below_in}; // [R18]
      sync_b <= sync_a; // [R18]
    end
  end

  logic any_below;
  logic all_release;
  logic all_chg_en;
  logic supply_high;
  assign any_below = |sync_b[N_CELLS-1:0];
  assign all_release = &sync_b[2*N_CELLS-1:N_CELLS];
  assign all_chg_en = &sync_b[3*N_CELLS-1:2*N_CELLS];
  assign supply_high = sync_b[SW-1];

  // ==========================================================================
  // command decode
  // ==========================================================================
  odsc_pkg::odsc_state_t state;
  logic [7:0] cfg;
  logic ctl_chg;
  logic ctl_dchg;
  logic od_flag;
  logic rel_done;
  logic fet_ok;
  logic take;
  logic take_cfg;
  logic take_ctl;
  logic det_expire;
  logic sleep_go;
  logic [31:0] det_cnt;
  logic [31:0] rel_cnt;
  logic [31:0] rst_cnt;
  logic [31:0] smp_cnt;

  assign link.cmd_ready = (state != odsc_pkg::ST_SLEEP); // [R9]
  assign take = link.cmd_valid && link.cmd_ready;
  assign take_cfg = take && (link.cmd_op == odsc_pkg::config_write_cmd);
  assign take_ctl = take && (link.cmd_op == odsc_pkg::control_write_cmd);
  assign link.dev_asleep = (state == odsc_pkg::ST_SLEEP);
  assign link.dev_od = od_flag;

  // check off means the level is treated as zero and always passes
  assign fet_ok = !cfg[odsc_pkg::CFG_CHECK_ON] || all_chg_en; // [R12]

  // ==========================================================================
  // configuration register
  // ==========================================================================
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg <= odsc_pkg::CFG_RESET;
    end else if (take_cfg) begin
      cfg <= link.cmd_data; // [R3] [R12]
    end
  end

  assign undervolt_sel_hi_out = cfg[odsc_pkg::CFG_UV_HI]; // [R3]
  assign undervolt_sel_lo_out = cfg[odsc_pkg::CFG_UV_LO]; // [R3]
  assign chg_enable_level_sel_hi_out = cfg[odsc_pkg::CFG_CE_HI]; // [R10]
  assign chg_enable_level_sel_lo_out = cfg[odsc_pkg::CFG_CE_LO]; // [R10]
  assign chg_enable_check_on_out = cfg[odsc_pkg::CFG_CHECK_ON];

  // ==========================================================================
  // detection countdown
  // ==========================================================================
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      det_cnt <= '0;
    end else if (state == odsc_pkg::ST_NORMAL && any_below && !det_expire) begin
      det_cnt <= det_cnt + 32'h1; // [R2] [R5]
    end else begin
      det_cnt <= '0; // [R19]
    end
  end

  assign det_expire = (state == odsc_pkg::ST_NORMAL) && any_below
                      && (det_cnt == 32'(DETECT_CYC - 1)); // [R2]
  assign sleep_go = !supply_high && (det_expire
                    || (take_ctl && link.cmd_data[odsc_pkg::CTL_SLEEP_REQ])); // [R6] [R13]

  // ==========================================================================
  // over-discharge flag and release timing
  // ==========================================================================
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      od_flag <= 1'b0;
    end else if (det_expire) begin
      od_flag <= 1'b1; // [R1]
    end else if (take_ctl && state == odsc_pkg::ST_NORMAL && fet_ok && rel_done
                 && ctl_chg && link.cmd_data[odsc_pkg::CTL_DCHG_FET]) begin
      od_flag <= 1'b0; // [R4]
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rel_cnt <= '0;
      rel_done <= 1'b0;
    end else if (!od_flag) begin
      rel_cnt <= '0;
      rel_done <= 1'b0;
    end else if (rel_done) begin
      rel_cnt <= '0;
    end else if (state == odsc_pkg::ST_NORMAL && ctl_chg && all_release) begin
      rel_cnt <= rel_cnt + 32'h1; // [R4] [R5]
      rel_done <= (rel_cnt == 32'(RELEASE_CYC - 1));
    end else begin
      rel_cnt <= '0; // [R19]
    end
  end

  // ==========================================================================
  // FET control bits
  // ==========================================================================
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctl_chg <= odsc_pkg::CTL_FET_RESET;
      ctl_dchg <= odsc_pkg::CTL_FET_RESET;
    end else if (det_expire) begin
      ctl_chg <= 1'b0; // [R14]
      ctl_dchg <= 1'b0; // [R15]
    end else if (take_ctl && state == odsc_pkg::ST_NORMAL && fet_ok) begin // [R8] [R11] [R16]
      ctl_chg <= link.cmd_data[odsc_pkg::CTL_CHG_FET]; // [R14]
      // after over-discharge, discharge waits for charge on and release done
      if (!od_flag || (rel_done && ctl_chg)) begin // [R4]
        ctl_dchg <= link.cmd_data[odsc_pkg::CTL_DCHG_FET]; // [R15]
      end
    end
  end

  // ==========================================================================
  // sleep and wake sequencing
  // ==========================================================================
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= odsc_pkg::ST_NORMAL;
    end else begin
      case (state)
        odsc_pkg::ST_NORMAL: begin
          if (sleep_go) begin
            state <= odsc_pkg::ST_SLEEP; // [R1] [R6]
          end
        end
        odsc_pkg::ST_SLEEP: begin
          if (supply_high) begin // [R9]
            state <= fet_ok ? odsc_pkg::ST_WAKE_RESET : odsc_pkg::ST_BLOCKED; // [R10]
          end
        end
        odsc_pkg::ST_BLOCKED: begin
          if (fet_ok) begin
            state <= odsc_pkg::ST_WAKE_RESET; // [R10]
          end
        end
        odsc_pkg::ST_WAKE_RESET: begin
          if (rst_cnt == 32'(RESET_CYC - 1)) begin
            state <= odsc_pkg::ST_NORMAL; // [R16]
          end
        end
        default: begin
          state <= odsc_pkg::ST_NORMAL;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_cnt <= '0;
    end else if (state == odsc_pkg::ST_WAKE_RESET) begin
      rst_cnt <= rst_cnt + 32'h1; // [R16]
    end else begin
      rst_cnt <= '0;
    end
  end

  // ==========================================================================
  // periodic sampling window
  // ==========================================================================
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      smp_cnt <= '0;
      sample_enable_out <= 1'b0;
    end else if (state == odsc_pkg::ST_NORMAL) begin
      smp_cnt <= (smp_cnt == 32'(SAMPLE_PERIOD_CYC - 1)) ? 32'h0 : smp_cnt + 32'h1; // [R17]
      sample_enable_out <= (smp_cnt < 32'(SAMPLE_ON_CYC)); // [R17]
    end else begin
      smp_cnt <= '0;
      sample_enable_out <= 1'b0; // [R7]
    end
  end

  // ==========================================================================
  // gate and regulator outputs
  // ==========================================================================
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      charge_gate_out <= 1'b1;
      discharge_gate_out <= 1'b1;
      regulator_output_on_out <= 1'b0;
      asleep_out <= 1'b0;
    end else begin
      // any state other than normal holds both FETs off
      charge_gate_out <= !(state == odsc_pkg::ST_NORMAL && fet_ok && ctl_chg
                           && !det_expire); // [R1] [R7] [R11] [R14]
      discharge_gate_out <= !(state == odsc_pkg::ST_NORMAL && fet_ok && ctl_dchg
                              && !det_expire); // [R1] [R7] [R11] [R15]
      regulator_output_on_out <= (state != odsc_pkg::ST_SLEEP); // [R7] [R9]
      asleep_out <= (state == odsc_pkg::ST_SLEEP); // [R7]
    end
  end

endmodule // odsc_device

// >>> odsc_host.sv
/*
  host-side controller: software orders config and control writes through a
  plain register port; the controller issues them on the link and reports
  device status with sticky interrupts. assumes same clock as the device.
*/
`timescale 1ns/1ns
module odsc_host (
  input wire logic sys_clk_in, // system clock
  input wire logic nrst_in, // async reset, active low
  input wire logic [7:0] reg_addr_in, // register byte address
  input wire logic [31:0] reg_wdata_in, // write data
  input wire logic reg_wr_in, // write strobe
  input wire logic reg_rd_in, // read strobe
  output logic [31:0] reg_rdata_out, // read data, cycle after strobe
  output logic irq_out, // level interrupt
  odsc_if.host link // device command link
);

  // ==========================================================================
  // command issue
  // ==========================================================================
  logic wr_cfg;
  logic wr_ctl;
  logic refused;
  logic asleep_d;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [2:0] events;

  assign wr_cfg = reg_wr_in && (reg_addr_in == odsc_pkg::HREG_CFG); // [R3] [R12]
  assign wr_ctl = reg_wr_in && (reg_addr_in == odsc_pkg::HREG_CTL); // [R6] [R14] [R15]
  assign refused = (wr_cfg || wr_ctl) && link.cmd_valid;

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      link.cmd_valid <= 1'b0;
      link.cmd_op <= odsc_pkg::config_write_cmd;
      link.cmd_data <= 8'h00;
    end else if ((wr_cfg || wr_ctl) && !link.cmd_valid) begin
      link.cmd_valid <= 1'b1;
      link.cmd_op <= wr_ctl ? odsc_pkg::control_write_cmd : odsc_pkg::config_write_cmd;
      link.cmd_data <= reg_wdata_in[7:0];
    end else if (link.cmd_valid && link.cmd_ready) begin
      link.cmd_valid <= 1'b0; // held while asleep until wake [R9]
    end
  end

  // ==========================================================================
  // interrupts
  // ==========================================================================
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      asleep_d <= 1'b0;
    end else begin
      asleep_d <= link.dev_asleep;
    end
  end

  always_comb begin
    events = 3'h0;
    events[odsc_pkg::IRQ_SLEEP] = link.dev_asleep && !asleep_d;
    events[odsc_pkg::IRQ_WAKE] = !link.dev_asleep && asleep_d;
    events[odsc_pkg::IRQ_REFUSED] = refused;
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_stat <= odsc_pkg::IRQ_RESET;
      irq_mask <= odsc_pkg::IRQ_RESET;
    end else begin
      // a set in the clearing cycle wins
      if (reg_wr_in && reg_addr_in == odsc_pkg::HREG_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~reg_wdata_in[2:0]) | events;
      end else begin
        irq_stat <= irq_stat | events;
      end
      if (reg_wr_in && reg_addr_in == odsc_pkg::HREG_IRQ_MASK) begin
        irq_mask <= reg_wdata_in[2:0];
      end
    end
  end

  assign irq_out = |(irq_stat & irq_mask);

  // ==========================================================================
  // read port
  // ==========================================================================
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= 32'h0;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        odsc_pkg::HREG_CFG: reg_rdata_out <= {24'h0, link.cmd_data};
        odsc_pkg::HREG_STATUS: begin
          reg_rdata_out <= {28'h0, link.dev_od, link.dev_asleep, link.cmd_ready,
                            link.cmd_valid};
        end
        odsc_pkg::HREG_IRQ_STAT: reg_rdata_out <= {29'h0, irq_stat};
        odsc_pkg::HREG_IRQ_MASK: reg_rdata_out <= {29'h0, irq_mask};
        default: reg_rdata_out <= 32'h0;
      endcase
    end else begin
      reg_rdata_out <= 32'h0;
    end
  end

endmodule // odsc_host

// >>> odsc_if.sv
/*
  command and status link between the host controller and the protection
  device. assumes both ends run on the same sys_clk_in.
*/
`timescale 1ns/1ns
interface odsc_if;
  logic cmd_valid;
  odsc_pkg::odsc_cmd_t cmd_op;
  logic [7:0] cmd_data;
  logic cmd_ready;
  logic dev_asleep;
  logic dev_od;

  modport device (
    input cmd_valid, cmd_op, cmd_data,
    output cmd_ready, dev_asleep, dev_od
  );
  modport host (
    output cmd_valid, cmd_op, cmd_data,
    input cmd_ready, dev_asleep, dev_od
  );
endinterface

// >>> odsc_link_sva.sv
/*
  concurrent checks on the host-device link and the device pins of the
  over-discharge block. assumes one clock and instantiation beside the link.
*/
`timescale 1ns/1ns
module odsc_link_sva #(
  parameter int N_CELLS = 4,
  parameter int DETECT_CYC = 20
) (
  input wire logic sys_clk_in, // system clock
  input wire logic nrst_in, // async reset, active low
  input wire logic cmd_valid, // host command pending
  input wire odsc_pkg::odsc_cmd_t cmd_op, // command kind
  input wire logic [7:0] cmd_data, // command payload
  input wire logic cmd_ready, // device accepts commands
  input wire logic dev_asleep, // device sleep state
  input wire logic dev_od, // over-discharge flag
  input wire logic [N_CELLS-1:0] uv_below_in, // raw undervoltage flags
  input wire logic supply_release_in, // supply at release level
  input wire logic discharge_gate_out, // high = discharge fet off
  input wire logic charge_gate_out, // high = charge fet off
  input wire logic regulator_output_on_out, // regulator enabled
  input wire logic asleep_out // device in sleep
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  // ==========================================================================
  // helper: consecutive cycles with any cell below threshold
  // ==========================================================================
  logic [7:0] uv_cnt;
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) uv_cnt <= 8'h00;
    else if (|uv_below_in) uv_cnt <= (uv_cnt == 8'hff) ? uv_cnt : uv_cnt + 8'h01;
    else uv_cnt <= 8'h00;
  end
  // ==========================================================================
  // properties
  // ==========================================================================
  property p_sleep_gates; asleep_out |-> discharge_gate_out && charge_gate_out; endproperty
  a_sleep_gates: assert property (p_sleep_gates) else $error("gate on in sleep");
  property p_sleep_reg; asleep_out |-> !regulator_output_on_out; endproperty
  a_sleep_reg: assert property (p_sleep_reg) else $error("regulator on in sleep");
  property p_ready; cmd_ready == !dev_asleep; endproperty
  a_ready: assert property (p_ready) else $error("link ready wrong");
  property p_od_gates; $rose(dev_od) |-> discharge_gate_out && charge_gate_out; endproperty
  a_od_gates: assert property (p_od_gates) else $error("gates on at od");
  property p_od_sleep; $rose(dev_od) && !$past(supply_release_in, 3) |-> ##[0:2] dev_asleep;
  endproperty
  a_od_sleep: assert property (p_od_sleep) else $error("no sleep after od");
  property p_no_sleep; $rose(asleep_out) |-> !$past(supply_release_in, 4); endproperty
  a_no_sleep: assert property (p_no_sleep) else $error("sleep with supply high");
  property p_detect; $rose(dev_od) |-> uv_cnt >= DETECT_CYC; endproperty
  a_detect: assert property (p_detect) else $error("od before delay");
  property p_od_dchg; dev_od |-> discharge_gate_out; endproperty
  a_od_dchg: assert property (p_od_dchg) else $error("discharge on in od");
  property p_chg_by_write;
    $fell(charge_gate_out) && dev_od
      |-> $past(cmd_valid && cmd_ready && cmd_op == odsc_pkg::control_write_cmd, 2);
  endproperty
  a_chg_by_write: assert property (p_chg_by_write) else $error("charge on unasked");
  c_od: cover property ($rose(dev_od));
  c_wake: cover property ($fell(asleep_out));
  c_od_clear: cover property ($fell(dev_od));
  c_stall: cover property (cmd_valid && !cmd_ready);
endmodule // odsc_link_sva

// >>> odsc_pkg.sv
/*
  shared constants and types for the over-discharge and sleep control block:
  timing, register field positions, reset values, host register offsets.
  assumes a single 250 MHz system clock on both ends.
*/
package odsc_pkg;

  // ==========================================================================
  // clock and timing
  // ==========================================================================
  localparam int CLK_KHZ = 250000;
  localparam int T_DETECT_MS = 1000;
  localparam int T_RELEASE_MS = 7;
  localparam int T_CHG_DETECT_MS = 1000;
  localparam int T_RESET_EXTRA_MS = 200;
  localparam int T_SAMPLE_ON_MS = 2;
  localparam int T_SAMPLE_PERIOD_MS = 125;
  localparam int DETECT_CYC = T_DETECT_MS * CLK_KHZ;
  localparam int RELEASE_CYC = T_RELEASE_MS * CLK_KHZ;
  localparam int RESET_CYC = ((T_DETECT_MS > T_CHG_DETECT_MS) ? T_DETECT_MS : T_CHG_DETECT_MS)
                             * CLK_KHZ + T_RESET_EXTRA_MS * CLK_KHZ;
  localparam int SAMPLE_ON_CYC = T_SAMPLE_ON_MS * CLK_KHZ;
  localparam int SAMPLE_PERIOD_CYC = T_SAMPLE_PERIOD_MS * CLK_KHZ;

  // ==========================================================================
  // device register fields
  // ==========================================================================
  localparam int CFG_UV_LO = 0;
  localparam int CFG_UV_HI = 1;
  localparam int CFG_CE_LO = 2;
  localparam int CFG_CE_HI = 3;
  localparam int CFG_CHECK_ON = 4;
  localparam int CTL_CHG_FET = 0;
  localparam int CTL_DCHG_FET = 1;
  localparam int CTL_SLEEP_REQ = 2;
  localparam logic [7:0] CFG_RESET = 8'h10;
  localparam logic CTL_FET_RESET = 1'h1;

  // ==========================================================================
  // host register map
  // ==========================================================================
  localparam logic [7:0] HREG_CFG = 8'h00;
  localparam logic [7:0] HREG_CTL = 8'h04;
  localparam logic [7:0] HREG_STATUS = 8'h08;
  localparam logic [7:0] HREG_IRQ_STAT = 8'h0c;
  localparam logic [7:0] HREG_IRQ_MASK = 8'h10;
  localparam int IRQ_SLEEP = 0;
  localparam int IRQ_WAKE = 1;
  localparam int IRQ_REFUSED = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef enum logic {
    config_write_cmd = 1'b0,
    control_write_cmd = 1'b1
  } odsc_cmd_t;

  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_SLEEP = 2'b01,
    ST_WAKE_RESET = 2'b10,
    ST_BLOCKED = 2'b11
  } odsc_state_t;

endpackage

// >>> tb_overdischarge_sleep_control.sv
/*
  self-checking bench: software register port drives the host, which talks
  to the device over the link. assumes shortened delay parameters.
*/
`timescale 1ns/1ns
module tb_overdischarge_sleep_control;
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [3:0] uv_below_in = 4'h0;
  logic [3:0] release_above_in = 4'h0;
  logic [3:0] chg_en_above_in = 4'hf;
  logic supply_release_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic irq_out, dchg_g, chg_g, reg_on, asleep, smp, uvh, uvl, ceh, cel, ckon;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_cycles = 0;
  int n;
  wire logic [4:0] dev_pins = {irq_out, dchg_g, chg_g, reg_on, asleep};
  wire logic [4:0] cfg_pins = {ckon, ceh, cel, uvh, uvl};
  odsc_if link_if();
  odsc_device #(.DETECT_CYC(20), .RELEASE_CYC(8), .RESET_CYC(16), .SAMPLE_ON_CYC(2),
    .SAMPLE_PERIOD_CYC(10)) odsc_device_inst (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
    .link(link_if), .uv_below_in(uv_below_in), .release_above_in(release_above_in),
    .chg_en_above_in(chg_en_above_in), .supply_release_in(supply_release_in),
    .discharge_gate_out(dchg_g), .charge_gate_out(chg_g), .regulator_output_on_out(reg_on),
    .undervolt_sel_hi_out(uvh), .undervolt_sel_lo_out(uvl), .chg_enable_level_sel_hi_out(ceh),
    .chg_enable_level_sel_lo_out(cel), .chg_enable_check_on_out(ckon),
    .sample_enable_out(smp), .asleep_out(asleep));
  odsc_host odsc_host_inst (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .irq_out(irq_out), .link(link_if));
  odsc_link_sva odsc_link_sva_inst (.sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in), .cmd_valid(link_if.cmd_valid), .cmd_op(link_if.cmd_op),
    .cmd_data(link_if.cmd_data), .cmd_ready(link_if.cmd_ready), .dev_asleep(link_if.dev_asleep),
    .dev_od(link_if.dev_od), .uv_below_in(uv_below_in), .supply_release_in(supply_release_in),
    .discharge_gate_out(dchg_g), .charge_gate_out(chg_g), .regulator_output_on_out(reg_on),
    .asleep_out(asleep));
  // ==========================================================================
  // clock, timeout, tasks
  // ==========================================================================
  always #2 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    n_cycles <= n_cycles + 1;
    if (n_cycles == 5000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge sys_clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out, exp);
    @(posedge sys_clk_in);
  endtask
  task automatic pins(input logic [4:0] exp);
    #1;
    chk({27'h0, dev_pins}, {27'h0, exp});
    @(posedge sys_clk_in);
  endtask
  task automatic cfgp(input logic [4:0] exp);
    #1;
    chk({27'h0, cfg_pins}, {27'h0, exp});
    @(posedge sys_clk_in);
  endtask
  // ==========================================================================
  // tests
  // ==========================================================================
  initial begin
    idle(20);
    nrst_in <= 1'b1;
    idle(6);
    pins(5'h02);
    cfgp(5'h10);
    rd(odsc_pkg::HREG_STATUS, 32'h2);
    rd(8'h20, 32'h0);
    rd(odsc_pkg::HREG_CTL, 32'h0);
    wr(odsc_pkg::HREG_IRQ_MASK, 32'h7);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wr(odsc_pkg::HREG_CFG, 32'h10 | i | (i << 2));
      idle(4);
      cfgp(5'(32'h10 | i | (i << 2)));
    end
    wr(odsc_pkg::HREG_CFG, 32'h00);
    chg_en_above_in <= 4'h0;
    idle(6);
    pins(5'h02);
    wr(odsc_pkg::HREG_CFG, 32'h10);
    idle(6);
    pins(5'h0e);
    wr(odsc_pkg::HREG_CTL, 32'h3);
    idle(6);
    pins(5'h0e);
    chg_en_above_in <= 4'hf;
    idle(6);
    pins(5'h02);
    $display("test charge enable check done");
    n = 0;
    repeat (20) begin
      @(posedge sys_clk_in);
      if (smp === 1'b1) n++;
    end
    chk(n, 32'h4);
    repeat (2) begin
      uv_below_in <= 4'h2;
      idle(15);
      uv_below_in <= 4'h0;
      idle(4);
    end
    idle(20);
    rd(odsc_pkg::HREG_STATUS, 32'h2);
    pins(5'h02);
    $display("test detect restart done");
    reg_addr_in <= odsc_pkg::HREG_CFG;
    reg_wdata_in <= 32'h11;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wdata_in <= 32'h12;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
    idle(4);
    cfgp(5'h11);
    pins(5'h12);
    rd(odsc_pkg::HREG_IRQ_STAT, 32'h4);
    wr(odsc_pkg::HREG_IRQ_STAT, 32'h7);
    $display("test refused write done");
    supply_release_in <= 1'b1;
    idle(4);
    wr(odsc_pkg::HREG_CTL, 32'h7);
    idle(6);
    pins(5'h02);
    supply_release_in <= 1'b0;
    idle(4);
    wr(odsc_pkg::HREG_CTL, 32'h7);
    idle(6);
    pins(5'h1d);
    wr(odsc_pkg::HREG_CTL, 32'h3);
    idle(6);
    pins(5'h1d);
    rd(odsc_pkg::HREG_STATUS, 32'h5);
    wr(odsc_pkg::HREG_IRQ_MASK, 32'h0);
    idle(2);
    pins(5'h0d);
    wr(odsc_pkg::HREG_IRQ_STAT, 32'h1);
    wr(odsc_pkg::HREG_IRQ_MASK, 32'h7);
    idle(2);
    pins(5'h0d);
    chg_en_above_in <= 4'h0;
    supply_release_in <= 1'b1;
    idle(30);
    pins(5'h1e);
    wr(odsc_pkg::HREG_CTL, 32'h3);
    idle(6);
    pins(5'h1e);
    chg_en_above_in <= 4'hf;
    idle(6);
    wr(odsc_pkg::HREG_CTL, 32'h0);
    idle(4);
    pins(5'h1e);
    idle(20);
    pins(5'h12);
    wr(odsc_pkg::HREG_CTL, 32'h1);
    idle(6);
    pins(5'h1a);
    wr(odsc_pkg::HREG_IRQ_STAT, 32'h7);
    $display("test manual sleep done");
    supply_release_in <= 1'b0;
    uv_below_in <= 4'hf;
    idle(30);
    pins(5'h1d);
    rd(odsc_pkg::HREG_STATUS, 32'hc);
    uv_below_in <= 4'h0;
    supply_release_in <= 1'b1;
    idle(40);
    pins(5'h1e);
    wr(odsc_pkg::HREG_CTL, 32'h1);
    idle(6);
    pins(5'h1a);
    wr(odsc_pkg::HREG_CTL, 32'h3);
    idle(6);
    pins(5'h1a);
    release_above_in <= 4'hf;
    idle(12);
    wr(odsc_pkg::HREG_CTL, 32'h3);
    idle(6);
    pins(5'h12);
    rd(odsc_pkg::HREG_STATUS, 32'h2);
    $display("test over-discharge done");
    summarize();
  end
endmodule // tb_overdischarge_sleep_control
